//--- lbfc_core.v
/*
 lbfc_core.v: light bar function control. turns level-sensed control head
 inputs into lamp group commands, with an apb register slave for options,
 pattern assignment and status.
 assumes: one 100 mhz clock pclk, async active-low presetn, control head
 inputs arrive asynchronously and may bounce; lamp drivers downstream
 interpret the pattern codes and flash requests.
*/
`timescale 1ns/1ps
`include "lbfc_map.vh"

module lbfc_core #(
   parameter PAT_W = 8,
   parameter DEB_CYCLES = (`LBFC_DEBOUNCE_US * 1000) / `LBFC_CLK_PERIOD_NS,
   parameter INT_HOLD_CYCLES = `LBFC_INT_HOLD_MS * (1000000 / `LBFC_CLK_PERIOD_NS),
   parameter PWM_DIV = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire mode1_in,
   input wire mode2_in,
   input wire mode3_in,
   input wire steady_burn_in,
   input wire intersection_in,
   input wire flash_takedown_alley_in,
   input wire left_alley_in,
   input wire right_alley_in,
   input wire takedown_in,
   input wire front_ctl_in,
   input wire rear_ctl_in,
   input wire low_power_in,
   input wire bar_test_in,
   input wire [7:0] dir_in,
   output reg [PAT_W-1:0] pattern_sel,
   output reg front_run,
   output reg rear_run,
   output reg steady_on,
   output reg takedown_steady,
   output reg takedown_flash,
   output reg left_alley_steady,
   output reg left_alley_flash,
   output reg right_alley_steady,
   output reg right_alley_flash,
   output reg scene_left,
   output reg scene_right,
   output reg self_test,
   output reg intensity_gate,
   output reg dir_internal_run,
   output reg dir_with_mode,
   output reg [7:0] dir_sel
);

   // ----------------------------------------
   // input synchronisation and debounce
   // ----------------------------------------
   localparam NIN = 21;
   wire [NIN-1:0] raw_in;
   reg [NIN-1:0] sync1_reg;
   reg [NIN-1:0] sync2_reg;
   reg [NIN-1:0] prev_reg;
   reg [NIN-1:0] clean_reg;
   reg [31:0] deb_cnt_reg;
   wire deb_tick;

   assign raw_in = {dir_in, bar_test_in, low_power_in, rear_ctl_in, front_ctl_in, takedown_in,
                    right_alley_in, left_alley_in, flash_takedown_alley_in, intersection_in,
                    steady_burn_in, mode3_in, mode2_in, mode1_in};
   assign deb_tick = (deb_cnt_reg == DEB_CYCLES - 1);

   // a level is accepted only after two equal samples one tick apart
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 21'h000000;
         sync2_reg <= 21'h000000;
         prev_reg <= 21'h000000;
         clean_reg <= 21'h000000;
         deb_cnt_reg <= 32'h00000000;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
         deb_cnt_reg <= deb_tick ? 32'h00000000 : deb_cnt_reg + 32'h00000001;
         if (deb_tick) begin
            prev_reg <= sync2_reg;
            clean_reg <= (prev_reg & sync2_reg) | (clean_reg & (prev_reg | sync2_reg));
         end
      end
   end

   wire m1 = clean_reg[0];
   wire m2 = clean_reg[1];
   wire m3 = clean_reg[2];
   wire sb = clean_reg[3];
   wire isec = clean_reg[4];
   wire fta = clean_reg[5];
   wire la = clean_reg[6];
   wire ra = clean_reg[7];
   wire td = clean_reg[8];
   wire fc = clean_reg[9];
   wire rc = clean_reg[10];
   wire lp = clean_reg[11];
   wire tst = clean_reg[12];
   wire [7:0] dirv = clean_reg[20:13];

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [4:0] ctrl_reg;
   reg [31:0] pattern_reg;
   wire pol_en = ctrl_reg[`LBFC_CTRL_POL_ENABLE];
   wire scene = ctrl_reg[`LBFC_CTRL_SCENE];
   wire [1:0] int_method = ctrl_reg[`LBFC_CTRL_INT_HI:`LBFC_CTRL_INT_LO];
   wire ext_dir = ctrl_reg[`LBFC_CTRL_EXT_DIR];

   // ----------------------------------------
   // mode priority and intersection
   // ----------------------------------------
   reg [1:0] mode_next;
   always @* begin
      if (m3) begin
         mode_next = 2'h3;
      end else if (m2) begin
         mode_next = 2'h2;
      end else if (m1) begin
         mode_next = 2'h1;
      end else begin
         mode_next = 2'h0;
      end
   end
   wire any_mode = (mode_next != 2'h0);

   reg isec_d_reg;
   reg lp_d_reg;
   reg int_latch_reg;
   reg [31:0] int_timer_reg;
   wire isec_rise = isec & ~isec_d_reg;
   wire lp_rise = lp & ~lp_d_reg;
   reg int_req;

   always @* begin
      case (int_method)
         `LBFC_INT_TOGGLE: int_req = int_latch_reg;
         `LBFC_INT_TIMED: int_req = (int_timer_reg != 32'h00000000);
         default: int_req = isec;
      endcase
   end
   // intersection overlays the mode; the stored selection is untouched so it resumes
   wire inter_act = int_req & any_mode & ~scene;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         isec_d_reg <= 1'b0;
         lp_d_reg <= 1'b0;
         int_latch_reg <= 1'b0;
         int_timer_reg <= 32'h00000000;
      end else begin
         isec_d_reg <= isec;
         lp_d_reg <= lp;
         if (int_method != `LBFC_INT_TOGGLE || scene) begin
            int_latch_reg <= 1'b0;
         end else if (isec_rise) begin
            int_latch_reg <= ~int_latch_reg;
         end
         if (int_method != `LBFC_INT_TIMED || scene) begin
            int_timer_reg <= 32'h00000000;
         end else if (isec_rise) begin
            int_timer_reg <= INT_HOLD_CYCLES;
         end else if (int_timer_reg != 32'h00000000) begin
            int_timer_reg <= int_timer_reg - 32'h00000001;
         end
      end
   end

   // ----------------------------------------
   // pattern selection and low power
   // ----------------------------------------
   reg [PAT_W-1:0] pat_next;
   always @* begin
      if (inter_act) begin
         pat_next = pattern_reg[31:24];
      end else if (mode_next == 2'h3) begin
         pat_next = pattern_reg[23:16];
      end else if (mode_next == 2'h2) begin
         pat_next = pattern_reg[15:8];
      end else begin
         // with no mode the mode-one code is shown; front_run and rear_run keep the heads dark
         pat_next = pattern_reg[7:0];
      end
   end

   reg [2:0] run_key_reg;
   reg dim_armed_reg;
   reg [7:0] pwm_cnt_reg;
   wire [2:0] run_key = {inter_act, mode_next};
   wire run_change = (run_key != run_key_reg);
   wire dim_ok = (mode_next == 2'h1 || mode_next == 2'h2) & ~inter_act & ~scene;
   wire dim_act = dim_armed_reg & lp & dim_ok;

   // a pattern change wins over a low-power edge in the same cycle, so the
   // operator must release and reapply after any change
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_key_reg <= 3'h0;
         dim_armed_reg <= 1'b0;
         pwm_cnt_reg <= 8'h00;
      end else begin
         run_key_reg <= run_key;
         pwm_cnt_reg <= (pwm_cnt_reg == PWM_DIV - 1) ? 8'h00 : pwm_cnt_reg + 8'h01;
         if (run_change || !lp) begin
            dim_armed_reg <= 1'b0;
         end else if (lp_rise) begin
            dim_armed_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // lamp group outputs
   // ----------------------------------------
   wire front_cut = pol_en ? ~fc : fc;
   wire rear_cut = pol_en ? ~rc : rc;
   wire fta_act = fta & any_mode;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pattern_sel <= {PAT_W{1'b0}};
         front_run <= 1'b0;
         rear_run <= 1'b0;
         steady_on <= 1'b0;
         takedown_steady <= 1'b0;
         takedown_flash <= 1'b0;
         left_alley_steady <= 1'b0;
         left_alley_flash <= 1'b0;
         right_alley_steady <= 1'b0;
         right_alley_flash <= 1'b0;
         scene_left <= 1'b0;
         scene_right <= 1'b0;
         self_test <= 1'b0;
         intensity_gate <= 1'b1;
         dir_internal_run <= 1'b0;
         dir_with_mode <= 1'b0;
         dir_sel <= 8'h00;
      end else begin
         pattern_sel <= pat_next;
         // with enable polarity front_run and rear_run stay dark until the head also raises front or rear
         front_run <= any_mode & ~front_cut;
         rear_run <= any_mode & ~rear_cut;
         steady_on <= sb & any_mode;
         takedown_steady <= td;
         takedown_flash <= fta_act & ~front_cut & ~td;
         left_alley_steady <= la;
         left_alley_flash <= fta_act & ~la;
         right_alley_steady <= ra;
         right_alley_flash <= fta_act & ~ra;
         scene_left <= scene & isec;
         scene_right <= scene & tst;
         self_test <= ~scene & tst;
         // half duty when dimmed; full on otherwise
         intensity_gate <= ~dim_act | (pwm_cnt_reg < PWM_DIV / 2);
         dir_internal_run <= ~ext_dir & (|dirv[6:0]);
         dir_with_mode <= ~ext_dir & ~(|dirv[6:0]) & any_mode;
         dir_sel <= ext_dir ? 8'h00 : dirv;
      end
   end

   // ----------------------------------------
   // apb slave, one wait state so read data comes from a flop
   // ----------------------------------------
   wire acc = psel & penable;
   wire hit_ctrl = (paddr == `LBFC_OFS_CTRL);
   wire hit_pat = (paddr == `LBFC_OFS_PATTERN);
   wire hit_stat = (paddr == `LBFC_OFS_STATUS);
   reg [31:0] rd_next;

   always @* begin
      if (hit_ctrl) begin
         rd_next = {27'h0000000, ctrl_reg};
      end else if (hit_pat) begin
         rd_next = pattern_reg;
      end else if (hit_stat) begin
         // dirv is the debounced level, so status lags the pins by the debounce span
         rd_next = {11'h000, dirv, dim_armed_reg, dim_act, inter_act, pattern_sel, mode_next};
      end else begin
         rd_next = 32'h00000000;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `LBFC_CTRL_RESET;
         pattern_reg <= `LBFC_PATTERN_RESET;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= acc & ~pready;
         // writes to status are dropped quietly; only unmapped offsets raise pslverr
         pslverr <= acc & ~pready & ~(hit_ctrl | hit_pat | hit_stat);
         if (acc & ~pready & ~pwrite) begin
            prdata <= rd_next;
         end
         if (acc & pready & pwrite) begin
            if (hit_ctrl) begin
               ctrl_reg <= pwdata[4:0];
            end else if (hit_pat) begin
               pattern_reg <= pwdata;
            end
         end
      end
   end

endmodule

//--- lbfc_map.vh
/*
 lbfc_map.vh: register offsets, field positions, reset values and timing
 constants for the light bar function control block.
 assumes: included by bare name from the design file; definitions only.
*/
`ifndef LBFC_MAP_VH
`define LBFC_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define LBFC_OFS_CTRL 12'h000
`define LBFC_OFS_PATTERN 12'h004
`define LBFC_OFS_STATUS 12'h008

// ----------------------------------------
// control register fields
// ----------------------------------------
`define LBFC_CTRL_POL_ENABLE 0
`define LBFC_CTRL_SCENE 1
`define LBFC_CTRL_INT_LO 2
`define LBFC_CTRL_INT_HI 3
`define LBFC_CTRL_EXT_DIR 4
`define LBFC_CTRL_RESET 5'h00

// intersection methods
`define LBFC_INT_MAINTAINED 2'h0
`define LBFC_INT_TOGGLE 2'h1
`define LBFC_INT_TIMED 2'h2

// ----------------------------------------
// pattern register reset (one byte per mode, then intersection)
// ----------------------------------------
`define LBFC_PATTERN_RESET 32'h04030201

// ----------------------------------------
// timing
// ----------------------------------------
`define LBFC_CLK_PERIOD_NS 10
`define LBFC_INT_HOLD_MS 8000
`define LBFC_DEBOUNCE_US 5000

`endif

//--- lbfc_monitor.sv
/*
 lbfc_monitor.sv: concurrent checks on the function control ports.
 assumes: bound to lbfc_core; one clock pclk, presetn async active low.
*/
`timescale 1ns/1ps
module lbfc_monitor (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire mode1_in,
   input wire mode2_in,
   input wire mode3_in,
   input wire steady_burn_in,
   input wire steady_on,
   input wire takedown_steady,
   input wire takedown_flash,
   input wire left_alley_steady,
   input wire left_alley_flash,
   input wire right_alley_steady,
   input wire right_alley_flash,
   input wire scene_left,
   input wire scene_right,
   input wire self_test
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // inputs pass a debouncer, so an absence must last before outputs follow
   sequence s_no_mode;
      (!mode1_in && !mode2_in && !mode3_in) [*8] ##4 1;
   endsequence
   sequence s_no_burn;
      !steady_burn_in [*8] ##4 1;
   endsequence
   sequence s_access;
      (psel && !penable) ##1 (psel && penable);
   endsequence
   property p_wait;
      s_access |-> !pready ##1 pready;
   endproperty
   property p_pulse;
      pready |=> !pready;
   endproperty
   property p_err;
      pslverr |-> pready;
   endproperty
   property p_burn;
      s_no_burn |-> !steady_on;
   endproperty
   property p_flash;
      s_no_mode |-> !takedown_flash && !left_alley_flash && !right_alley_flash;
   endproperty
   property p_td;
      takedown_steady |-> !takedown_flash;
   endproperty
   property p_left;
      left_alley_steady |-> !left_alley_flash;
   endproperty
   property p_right;
      right_alley_steady |-> !right_alley_flash;
   endproperty
   property p_scene;
      scene_left || scene_right |-> !self_test;
   endproperty
   a_wait: assert property (p_wait)
      else $error("apb answer not after one wait state");
   a_pulse: assert property (p_pulse)
      else $error("pready longer than one cycle");
   a_err: assert property (p_err)
      else $error("pslverr without pready");
   a_burn: assert property (p_burn)
      else $error("steady lamps without their input");
   a_flash: assert property (p_flash)
      else $error("flashing takedown or alley without a mode");
   a_td: assert property (p_td)
      else $error("takedown flashes while steady");
   a_left: assert property (p_left)
      else $error("left alley flashes while steady");
   a_right: assert property (p_right)
      else $error("right alley flashes while steady");
   a_scene: assert property (p_scene)
      else $error("self test during scene lighting");
endmodule

//--- lbfc_head.sv
/*
 lbfc_head.sv: control head model driving switch levels into the block.
 assumes: the testbench asks for a switch setting; levels move after pclk rises.
*/
`timescale 1ns/1ps
module lbfc_head (
   input wire pclk,
   input wire [20:0] req,
   output reg [20:0] head
);
   // ----------------------------------------
   // switch levels
   // ----------------------------------------
   initial head = 21'h000000;
   // a real head holds its switches far longer than the debounce span
   // with enable polarity, mode and front or rear are asserted together
   always @(posedge pclk) begin
      head <= req;
   end
endmodule

//--- lbfc_tb.sv
/*
 lbfc_tb.sv: self-checking bench, apb register access and switch scenarios.
 assumes: DEB_CYCLES 2 and INT_HOLD_CYCLES 50, so every state but the timed intersection hold settles in 20 cycles.
*/
`timescale 1ns/1ps
module testbench;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h00000000, rd;
   reg [20:0] req = 21'h000000;
   wire [20:0] h;
   wire [31:0] prdata;
   wire [7:0] pattern_sel, dir_sel;
   wire pready, pslverr, front_run, rear_run, steady_on, takedown_steady, takedown_flash;
   wire left_alley_steady, left_alley_flash, right_alley_steady, right_alley_flash;
   wire scene_left, scene_right, self_test, intensity_gate, dir_internal_run, dir_with_mode;
   wire [19:0] f = {pattern_sel, front_run, rear_run, steady_on, takedown_steady, takedown_flash,
      left_alley_steady, left_alley_flash, right_alley_steady, right_alley_flash, scene_left, scene_right, self_test};
   integer errors = 0, checks_done = 0, n;
   always #5 pclk = ~pclk;
   lbfc_head lbfc_head_inst (.pclk(pclk), .req(req), .head(h));
   lbfc_core #(.DEB_CYCLES(2), .INT_HOLD_CYCLES(50)) lbfc_core_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mode1_in(h[0]), .mode2_in(h[1]),
      .mode3_in(h[2]), .steady_burn_in(h[3]), .intersection_in(h[4]), .flash_takedown_alley_in(h[5]),
      .left_alley_in(h[6]), .right_alley_in(h[7]), .takedown_in(h[8]), .front_ctl_in(h[9]),
      .rear_ctl_in(h[10]), .low_power_in(h[11]), .bar_test_in(h[12]), .dir_in(h[20:13]),
      .pattern_sel(pattern_sel), .front_run(front_run), .rear_run(rear_run), .steady_on(steady_on),
      .takedown_steady(takedown_steady), .takedown_flash(takedown_flash),
      .left_alley_steady(left_alley_steady), .left_alley_flash(left_alley_flash),
      .right_alley_steady(right_alley_steady), .right_alley_flash(right_alley_flash),
      .scene_left(scene_left), .scene_right(scene_right), .self_test(self_test),
      .intensity_gate(intensity_gate), .dir_internal_run(dir_internal_run),
      .dir_with_mode(dir_with_mode), .dir_sel(dir_sel));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task finish_test;
      if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input [31:0] s, input [31:0] e);
      checks_done = checks_done + 1;
      if (s !== e) begin
         errors = errors + 1;
         $display("mismatch %s exp %h got %h", nm, e, s);
      end
   endtask
   // request held until pready is sampled high, data taken at that edge
   task apb(input w, input [11:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task st(input [20:0] v, input [19:0] e);
      req <= v;
      repeat (20) @(posedge pclk);
      chk("outputs", {12'h000, f}, {12'h000, e});
   endtask
   // a 16-cycle window of a half-duty square wave holds exactly 8 low cycles
   task dim(input [20:0] v, input [31:0] e);
      req <= v;
      repeat (20) @(posedge pclk);
      n = 0;
      repeat (16) begin
         @(posedge pclk);
         if (intensity_gate === 1'b0) n = n + 1;
      end
      chk("dimmed", n, e);
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (5000) @(posedge pclk);
      errors = errors + 1;
      finish_test;
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h00000000);
      chk("ctrl", rd, 32'h00000000);
      apb(1'b0, 12'h004, 32'h00000000);
      chk("pattern", rd, 32'h04030201);
      apb(1'b0, 12'h00C, 32'h00000000);
      chk("slverr", {31'h00000000, er}, 32'h00000001);
      chk("badrd", rd, 32'h00000000);
      apb(1'b1, 12'h004, 32'h44332211);
      apb(1'b0, 12'h004, 32'h00000000);
      chk("pattern", rd, 32'h44332211);
      st(21'h000001, 20'h11C00);
      chk("dmode", {31'h00000000, dir_with_mode}, 32'h00000001);
      st(21'h000003, 20'h22C00);
      st(21'h000007, 20'h33C00);
      // with no mode pattern_sel goes back to the mode-one code while every head is dark
      st(21'h000008, 20'h11000);
      st(21'h000009, 20'h11E00);
      st(21'h000201, 20'h11400);
      st(21'h000401, 20'h11800);
      st(21'h000021, 20'h11CA8);
      st(21'h000061, 20'h11CC8);
      st(21'h0000A1, 20'h11CB0);
      st(21'h000221, 20'h11428);
      st(21'h000321, 20'h11528);
      st(21'h000011, 20'h44C00);
      st(21'h000001, 20'h11C00);
      st(21'h001001, 20'h11C01);
      st(21'h002001, 20'h11C00);
      chk("dsel", {24'h000000, dir_sel}, 32'h00000001);
      chk("drun", {31'h00000000, dir_internal_run}, 32'h00000001);
      chk("dmode", {31'h00000000, dir_with_mode}, 32'h00000000);
      st(21'h000001, 20'h11C00);
      dim(21'h000801, 32'h00000008);
      dim(21'h000805, 32'h00000000);
      dim(21'h000801, 32'h00000000);
      st(21'h000001, 20'h11C00);
      dim(21'h000801, 32'h00000008);
      dim(21'h000811, 32'h00000000);
      st(21'h000003, 20'h22C00);
      dim(21'h000803, 32'h00000008);
      st(21'h000001, 20'h11C00);
      apb(1'b1, 12'h000, 32'h00000001);
      st(21'h000001, 20'h11000);
      st(21'h000201, 20'h11800);
      st(21'h000401, 20'h11400);
      apb(1'b1, 12'h000, 32'h00000002);
      st(21'h000011, 20'h11C04);
      st(21'h001011, 20'h11C06);
      st(21'h000001, 20'h11C00);
      apb(1'b1, 12'h000, 32'h00000004);
      st(21'h000011, 20'h44C00);
      st(21'h000001, 20'h44C00);
      st(21'h000011, 20'h11C00);
      st(21'h000001, 20'h11C00);
      apb(1'b1, 12'h000, 32'h00000008);
      st(21'h000011, 20'h44C00);
      st(21'h000001, 20'h44C00);
      repeat (60) @(posedge pclk);
      st(21'h000001, 20'h11C00);
      apb(1'b1, 12'h000, 32'h00000010);
      st(21'h002001, 20'h11C00);
      chk("dsel", {24'h000000, dir_sel}, 32'h00000000);
      chk("drun", {31'h00000000, dir_internal_run}, 32'h00000000);
      chk("dmode", {31'h00000000, dir_with_mode}, 32'h00000000);
      apb(1'b0, 12'h008, 32'h00000000);
      chk("status", rd, 32'h00002045);
      finish_test;
   end
endmodule
bind lbfc_core lbfc_monitor lbfc_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .mode1_in(mode1_in), .mode2_in(mode2_in), .mode3_in(mode3_in),
   .steady_burn_in(steady_burn_in), .steady_on(steady_on), .takedown_steady(takedown_steady),
   .takedown_flash(takedown_flash), .left_alley_steady(left_alley_steady), .left_alley_flash(left_alley_flash),
   .right_alley_steady(right_alley_steady), .right_alley_flash(right_alley_flash), .scene_left(scene_left),
   .scene_right(scene_right), .self_test(self_test));
